// ==== dpr_ram.sv ====
// Dual-port RAM with selectable port clocking schemes
`timescale 1ns/1ps
`default_nettype none
`include "dpr_map.svh"

module dpr_ram import dpr_pkg::*; #(
  parameter int ADDR_W = `DPR_ADDR_W,
  parameter int DATA_W = `DPR_DATA_W,
  parameter int BE_W   = `DPR_DATA_W / `DPR_LANE_W
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire dpr_mode_type      mode,
  input  wire logic              sp_split,
  input  wire logic              tick_0,
  input  wire logic              tick_1,
  input  wire logic              ce_a_in,
  input  wire logic              ce_a_out,
  input  wire logic              ce_b_in,
  input  wire logic              ce_b_out,
  input  wire logic              clr_a_in,
  input  wire logic              clr_a_out,
  input  wire logic              clr_b_in,
  input  wire logic              clr_b_out,
  input  wire logic [ADDR_W-1:0] a_addr,
  input  wire logic [DATA_W-1:0] a_din,
  input  wire logic              a_we,
  input  wire logic [BE_W-1:0]   a_be,
  input  wire logic              a_outreg,
  output logic      [DATA_W-1:0] a_dout,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic [DATA_W-1:0] b_din,
  input  wire logic              b_we,
  input  wire logic [BE_W-1:0]   b_be,
  input  wire logic              b_rd_en,
  input  wire logic              b_outreg,
  output logic      [DATA_W-1:0] b_dout
);

  localparam int DEPTH    = 1 << ADDR_W;
  localparam int SP_WORDS = `DPR_SP_MAX_BITS / DATA_W;
  localparam logic [ADDR_W-1:0] SP_BASE = ADDR_W'(SP_WORDS);

  logic              rst_meta_reg;
  logic              rst_sync_reg;
  logic              a_in_tick, a_out_tick, b_in_tick, b_out_tick;
  logic              a_clr_out, b_clr_out, b_use_rden, b_wr_ok, split_on;
  logic [ADDR_W-1:0] a_addr_q, b_addr_q, a_ea, b_ea;
  logic [DATA_W-1:0] a_din_q, b_din_q, a_mem_q, b_mem_q;
  logic [BE_W-1:0]   a_be_q, b_be_q;
  logic              a_fire, b_fire, a_do_wr, b_do_wr;
  logic [DATA_W-1:0] mem [DEPTH];

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // merge only the enabled byte lanes
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [BE_W-1:0]   be);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int l = 0; l < BE_W; l++) begin
      if (be[l]) res[l*`DPR_LANE_W +: `DPR_LANE_W] =
        new_w[l*`DPR_LANE_W +: `DPR_LANE_W];
    end
    return res;
  endfunction

  // split puts the second single-port RAM above the first
  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic              upper,
    input logic [ADDR_W-1:0] addr);
    return upper ? ADDR_W'(addr + SP_BASE) : addr;
  endfunction

  // Tick and clear routing per clocking scheme
  // Clears are steered combinationally, so mode must be static in use
  always_comb begin
    a_in_tick  = tick_0 & ce_a_in;
    a_out_tick = tick_0 & ce_a_in;
    b_in_tick  = tick_1 & ce_b_in;
    b_out_tick = tick_1 & ce_b_in;
    a_clr_out  = clr_a_in;
    b_clr_out  = clr_b_in;
    b_use_rden = 1'b0;
    b_wr_ok    = 1'b1;
    case (mode)
      // each port on its own tick
      // one enable and clear per port
      DPR_MODE_INDEP: begin
      end
      // inputs of both ports on tick 0
      // output group has own enable and clear
      DPR_MODE_INOUT: begin
        a_out_tick = tick_1 & ce_a_out;
        b_in_tick  = tick_0 & ce_b_in;
        b_out_tick = tick_1 & ce_b_out;
        a_clr_out  = clr_a_out;
        b_clr_out  = clr_b_out;
      end
      // port A is the write side on tick 0
      // port B is the read side on tick 1
      DPR_MODE_RDWR: begin
        b_use_rden = 1'b1;
        b_wr_ok    = 1'b0;
      end
      // port B writes only when split
      DPR_MODE_SINGLE: begin
        b_wr_ok = sp_split;
      end
      default: begin
        b_wr_ok = 1'b0;
      end
    endcase
  end

  assign split_on = (mode == DPR_MODE_SINGLE) && sp_split;
  assign a_ea     = a_addr_q;
  assign b_ea     = eff_addr(split_on, b_addr_q);

  assign a_do_wr = a_fire && (!split_on || a_addr_q < SP_BASE);
  assign b_do_wr = b_fire && b_wr_ok && (!split_on || b_addr_q < SP_BASE);

  // Combinational array read at the registered address
  assign a_mem_q = mem[a_ea];
  assign b_mem_q = mem[b_ea];

  // write with lane mask; port B wins an address collision
  always_ff @(posedge core_clk) begin
    if (a_do_wr) mem[a_ea] <= lane_merge(mem[a_ea], a_din_q, a_be_q);
    if (b_do_wr) mem[b_ea] <= lane_merge(mem[b_ea], b_din_q, b_be_q);
  end

  dpr_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .BE_W(BE_W)) u_port_a (
    .core_clk    (core_clk),
    .rst_n       (rst_sync_reg),
    .in_tick     (a_in_tick),
    .out_tick    (a_out_tick),
    .clr_in      (clr_a_in),
    .clr_out     (a_clr_out),
    .use_rden    (1'b0),
    .rd_en       (1'b0),
    .out_reg_use (a_outreg),
    .addr        (a_addr),
    .din         (a_din),
    .we          (a_we),
    .be          (a_be),
    .mem_q       (a_mem_q),
    .addr_q      (a_addr_q),
    .din_q       (a_din_q),
    .be_q        (a_be_q),
    .wr_fire_q   (a_fire),
    .dout        (a_dout)
  );

  dpr_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .BE_W(BE_W)) u_port_b (
    .core_clk    (core_clk),
    .rst_n       (rst_sync_reg),
    .in_tick     (b_in_tick),
    .out_tick    (b_out_tick),
    .clr_in      (clr_b_in),
    .clr_out     (b_clr_out),
    .use_rden    (b_use_rden),
    .rd_en       (b_rd_en),
    .out_reg_use (b_outreg),
    .addr        (b_addr),
    .din         (b_din),
    .we          (b_we),
    .be          (b_be),
    .mem_q       (b_mem_q),
    .addr_q      (b_addr_q),
    .din_q       (b_din_q),
    .be_q        (b_be_q),
    .wr_fire_q   (b_fire),
    .dout        (b_dout)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_reg);

  a_indep_b_idle: assert property (
    mode == DPR_MODE_INDEP && !tick_1 && !clr_b_in ##1 !clr_b_in
    |-> $stable(b_addr_q))
    else $error("port B moved on the port A tick");
  a_inout_oclr: assert property (
    mode == DPR_MODE_INOUT && clr_a_out && a_outreg
    |-> a_dout == '0)
    else $error("output clear did not zero port A output");
  a_rdwr_write: assert property (
    mode == DPR_MODE_RDWR && tick_0 && ce_a_in && a_we && !clr_a_in
    ##1 !clr_a_in |-> a_fire && a_addr_q == $past(a_addr))
    else $error("write side did not take its tick");
  a_rdwr_read: assert property (
    mode == DPR_MODE_RDWR && tick_1 && ce_b_in && !clr_b_in
    ##1 !clr_b_in |-> b_addr_q == $past(b_addr))
    else $error("read side did not take its tick");
  a_rdwr_ce_gate: assert property (
    mode == DPR_MODE_RDWR && !ce_b_in && !clr_b_in ##1 !clr_b_in
    |-> $stable(b_addr_q))
    else $error("read side moved with enable low");
  a_rdwr_no_bwr: assert property (
    mode == DPR_MODE_RDWR |-> !b_do_wr)
    else $error("read side wrote the array");
  a_split_range: assert property (
    a_fire && split_on && a_addr_q >= SP_BASE |-> !a_do_wr)
    else $error("split RAM wrote outside its half");
  a_lane_keep: assert property (
    a_do_wr && !b_do_wr && !a_be_q[0]
    |=> mem[$past(a_ea)][`DPR_LANE_W-1:0]
        == $past(mem[a_ea][`DPR_LANE_W-1:0]))
    else $error("disabled lane changed");
  a_lane_write: assert property (
    a_do_wr && !b_do_wr && a_be_q[0]
    |=> mem[$past(a_ea)][`DPR_LANE_W-1:0]
        == $past(a_din_q[`DPR_LANE_W-1:0]))
    else $error("enabled lane not written");

endmodule // dpr_ram

`default_nettype wire

// ==== dpr_map.svh ====
// Constants for the dual-port RAM clocking block
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH

// Default geometry: 8K words of 72 bits, 9-bit byte lanes
`define DPR_ADDR_W       13
`define DPR_DATA_W       72
`define DPR_LANE_W       9

// Largest size of each half when one block hosts two single-port RAMs
`define DPR_SP_MAX_BITS  2048

// Reset value of the write-fire and read strobe registers
`define DPR_CLR_VAL      1'b0

`endif

// ==== dpr_pkg.sv ====
// Types shared by the dual-port RAM clocking block
`default_nettype none

package dpr_pkg;

  // Clocking scheme of the block, one-hot
  typedef enum logic [3:0] {
    DPR_MODE_INDEP  = 4'h1,
    DPR_MODE_INOUT  = 4'h2,
    DPR_MODE_RDWR   = 4'h4,
    DPR_MODE_SINGLE = 4'h8
  } dpr_mode_type;

endpackage

`default_nettype wire

// ==== dpr_port.sv ====
// One RAM port: input register group, read strobe and output register
`timescale 1ns/1ps
`default_nettype none
`include "dpr_map.svh"

module dpr_port import dpr_pkg::*; #(
  parameter int ADDR_W = `DPR_ADDR_W,
  parameter int DATA_W = `DPR_DATA_W,
  parameter int BE_W   = `DPR_DATA_W / `DPR_LANE_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              in_tick,
  input  wire logic              out_tick,
  input  wire logic              clr_in,
  input  wire logic              clr_out,
  input  wire logic              use_rden,
  input  wire logic              rd_en,
  input  wire logic              out_reg_use,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              we,
  input  wire logic [BE_W-1:0]   be,
  input  wire logic [DATA_W-1:0] mem_q,
  output logic      [ADDR_W-1:0] addr_q,
  output logic      [DATA_W-1:0] din_q,
  output logic      [BE_W-1:0]   be_q,
  output logic                   wr_fire_q,
  output logic      [DATA_W-1:0] dout
);

  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] din_reg;
  logic [BE_W-1:0]   be_reg;
  logic              wr_fire_reg;
  logic              rden_reg;
  logic [DATA_W-1:0] q_reg;

  // input group on its own tick
  // clear zeroes the group at once
  always_ff @(posedge core_clk or negedge rst_n or posedge clr_in) begin
    if (!rst_n) begin
      addr_reg    <= '0;
      din_reg     <= '0;
      be_reg      <= '0;
      wr_fire_reg <= `DPR_CLR_VAL;
    end else if (clr_in) begin
      addr_reg    <= '0;
      din_reg     <= '0;
      be_reg      <= '0;
      wr_fire_reg <= `DPR_CLR_VAL;
    end else begin
      if (in_tick) begin
        addr_reg <= addr;
        din_reg  <= din;
        be_reg   <= be;
      end
      wr_fire_reg <= in_tick & we;
    end
  end

  // read strobe ignores the port clears
  // Only the block reset touches it, so it still has a defined start
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rden_reg <= `DPR_CLR_VAL;
    end else if (in_tick) begin
      rden_reg <= rd_en;
    end
  end

  // output register on the output tick only
  always_ff @(posedge core_clk or negedge rst_n or posedge clr_out) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else if (clr_out) begin
      q_reg <= '0;
    end else if (out_tick && (!use_rden || rden_reg)) begin
      q_reg <= mem_q;
    end
  end

  // bypass gives the raw array read path
  assign dout      = out_reg_use ? q_reg : mem_q;
  assign addr_q    = addr_reg;
  assign din_q     = din_reg;
  assign be_q      = be_reg;
  assign wr_fire_q = wr_fire_reg;

  sequence s_quiet_in;
    !in_tick && !clr_in ##1 !clr_in;
  endsequence

  sequence s_take_in;
    in_tick && !clr_in ##1 !clr_in;
  endsequence

  a_clear_in_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    clr_in |-> (addr_reg == '0) && !wr_fire_reg)
    else $error("input group not zero under clear");
  a_hold_in_regs: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_quiet_in |-> $stable(addr_reg) && $stable(din_reg))
    else $error("input group moved without its tick");
  a_take_in_regs: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_take_in |-> addr_reg == $past(addr) && be_reg == $past(be))
    else $error("input group missed its tick");
  a_out_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
    out_tick && !clr_out && (!use_rden || rden_reg) ##1 !clr_out
    |-> q_reg === $past(mem_q))
    else $error("output register missed its tick");
  a_rden_no_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
    in_tick |=> rden_reg == $past(rd_en))
    else $error("read strobe register disturbed");
  a_rden_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !in_tick |=> $stable(rden_reg))
    else $error("read strobe moved without its tick");
  a_reg_out_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    out_reg_use && !out_tick && !clr_out ##1 out_reg_use && !clr_out
    |-> $stable(dout))
    else $error("registered output moved without tick");

endmodule // dpr_port

`default_nettype wire

// ==== dpr_fabric.sv ====
// Fabric-side model that presents port B requests to the RAM
`timescale 1ns/1ps
`default_nettype none

module dpr_fabric (
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [12:0] addr,
  input  wire logic [71:0] din,
  input  wire logic        we,
  input  wire logic [7:0]  be,
  input  wire logic        rd,
  output logic      [12:0] b_addr,
  output logic      [71:0] b_din,
  output logic             b_we,
  output logic      [7:0]  b_be,
  output logic             b_rd_en
);
  logic [71:0] scr_reg = 72'h5A3C_96F0_0FF0_C3A5_5A;

  // Idle pattern flips each cycle so stale data never looks valid
  always @(negedge core_clk) begin
    scr_reg <= ~scr_reg;
  end

  // stable request lines
  // Bench raises go just after a falling edge and holds it a full cycle
  always_comb begin
    if (go) begin
      b_addr  = addr;
      b_din   = din;
      b_we    = we;
      b_be    = be;
      b_rd_en = rd;
    end else begin
      b_addr  = scr_reg[12:0];
      b_din   = scr_reg;
      b_we    = 1'b0;
      b_be    = scr_reg[7:0];
      b_rd_en = 1'b0;
    end
  end
endmodule // dpr_fabric

`default_nettype wire

// ==== dpr_ram_tb.sv ====
// Self-checking bench for the dual-port RAM clocking block
`timescale 1ns/1ps
`default_nettype none
`include "dpr_map.svh"

module dpr_ram_tb import dpr_pkg::*;;
  typedef struct {logic sel; logic [71:0] v;} dpr_note_type;

  logic         core_clk = 1'b0;
  logic         arst_n = 1'b0;
  dpr_mode_type mode = DPR_MODE_INDEP;
  logic         tick_0, tick_1, a_we, a_outreg, b_outreg;
  logic         ce_a_in, ce_a_out, ce_b_in, ce_b_out;
  logic         clr_a_in, clr_a_out, clr_b_in, clr_b_out;
  logic [12:0]  a_addr, f_addr, b_addr, ad;
  logic [71:0]  a_din, f_din, b_din, a_dout, b_dout, d0, d1;
  logic [7:0]   a_be, f_be, b_be;
  logic         f_go, f_we, f_rd, b_we, b_rd_en, obs_req;
  dpr_note_type notes[$];
  dpr_note_type note;
  int           fail_count = 0;
  int           checks = 0;
  logic         sp_split = 1'b0;
  // Word offset of the second single-port RAM while split
  localparam logic [12:0] SP_OFF = 13'(`DPR_SP_MAX_BITS / `DPR_DATA_W);

  dpr_ram i_dut (.core_clk(core_clk), .arst_n(arst_n), .mode(mode),
    .sp_split(sp_split), .tick_0(tick_0), .tick_1(tick_1),
    .ce_a_in(ce_a_in), .ce_a_out(ce_a_out), .ce_b_in(ce_b_in),
    .ce_b_out(ce_b_out), .clr_a_in(clr_a_in), .clr_a_out(clr_a_out),
    .clr_b_in(clr_b_in), .clr_b_out(clr_b_out), .a_addr(a_addr),
    .a_din(a_din), .a_we(a_we), .a_be(a_be), .a_outreg(a_outreg),
    .a_dout(a_dout), .b_addr(b_addr), .b_din(b_din), .b_we(b_we),
    .b_be(b_be), .b_rd_en(b_rd_en), .b_outreg(b_outreg),
    .b_dout(b_dout));

  dpr_fabric i_fabric (.core_clk(core_clk), .go(f_go), .addr(f_addr),
    .din(f_din), .we(f_we), .be(f_be), .rd(f_rd), .b_addr(b_addr),
    .b_din(b_din), .b_we(b_we), .b_be(b_be), .b_rd_en(b_rd_en));

  // Clock at 25 MHz
  always #20 core_clk = ~core_clk;

  task automatic cmp(input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [71:0] rnd72();
    return 72'({$urandom(), $urandom(), $urandom()});
  endfunction

  // One port request, held a full cycle around its taking edge
  task automatic op(input logic sel, input logic [12:0] a,
                    input logic [71:0] d, input logic we,
                    input logic [7:0] be, input logic rd);
    @(negedge core_clk);
    if (sel) begin
      f_addr = a;
      f_din = d;
      f_we = we;
      f_be = be;
      f_rd = rd;
      f_go = 1'b1;
      tick_1 = 1'b1;
    end else begin
      a_addr = a;
      a_din = d;
      a_we = we;
      a_be = be;
      tick_0 = 1'b1;
    end
    @(negedge core_clk);
    f_go = 1'b0;
    tick_0 = 1'b0;
    tick_1 = 1'b0;
    a_we = 1'b0;
    @(negedge core_clk);
  endtask

  // Note an expected read value; the watcher samples at the next edge
  task automatic expect_dout(input logic sel, input logic [71:0] v);
    notes.push_back('{sel, v});
    obs_req = 1'b1;
    @(negedge core_clk);
    obs_req = 1'b0;
  endtask

  // Watcher: pairs each sampled output with the oldest note
  always @(posedge core_clk) begin
    if (obs_req) begin
      if (notes.size() == 0) begin
        cmp(72'h0, 72'h1);
      end else begin
        note = notes.pop_front();
        cmp(note.sel ? b_dout : a_dout, note.v);
      end
    end
  end

  initial begin
    {tick_0, tick_1, a_we, a_outreg, b_outreg, f_go, f_we, f_rd} = 8'h00;
    {clr_a_in, clr_a_out, clr_b_in, clr_b_out, obs_req} = 5'h00;
    {ce_a_in, ce_a_out, ce_b_in, ce_b_out} = 4'hF;
    {a_addr, f_addr, a_be, f_be} = {26'h0, 16'hFFFF};
    {a_din, f_din} = 144'h0;
    void'($urandom(83));
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    // Independent ports, B merges lanes 0..3 over A's word
    ad = 13'($urandom());
    d0 = rnd72();
    d1 = rnd72();
    op(1'b0, ad, d0, 1'b1, 8'hFF, 1'b0);
    op(1'b1, ad, d1, 1'b1, 8'h0F, 1'b0);
    op(1'b0, ad, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b0, {d0[71:36], d1[35:0]});
    op(1'b1, ad, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b1, {d0[71:36], d1[35:0]});
    // Port B enable low: its write must not land
    ce_b_in = 1'b0;
    op(1'b1, ad, d0, 1'b1, 8'hFF, 1'b0);
    ce_b_in = 1'b1;
    op(1'b0, ad, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b0, {d0[71:36], d1[35:0]});
    // Input/output clocking: tick_0 takes address, tick_1 loads output
    mode = DPR_MODE_INOUT;
    a_outreg = 1'b1;
    op(1'b0, ad, d1, 1'b1, 8'hFF, 1'b0);
    expect_dout(1'b0, {d0[71:36], d1[35:0]});
    op(1'b1, 13'h0, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b0, d1);
    clr_a_in = 1'b1;
    expect_dout(1'b0, d1);
    clr_a_in = 1'b0;
    clr_a_out = 1'b1;
    expect_dout(1'b0, 72'h0);
    op(1'b1, 13'h0, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b0, 72'h0);
    clr_a_out = 1'b0;
    // Read/write clocking: A writes, B only reads
    mode = DPR_MODE_RDWR;
    b_outreg = 1'b1;
    d0 = rnd72();
    op(1'b0, ad + 13'h1, d0, 1'b1, 8'hFF, 1'b0);
    op(1'b1, ad + 13'h1, rnd72(), 1'b1, 8'hFF, 1'b0);
    op(1'b1, ad + 13'h1, 72'h0, 1'b0, 8'hFF, 1'b1);
    op(1'b1, ad + 13'h1, 72'h0, 1'b0, 8'hFF, 1'b1);
    expect_dout(1'b1, d0);
    ce_b_in = 1'b0;
    op(1'b1, ad, 72'h0, 1'b0, 8'hFF, 1'b1);
    op(1'b1, ad, 72'h0, 1'b0, 8'hFF, 1'b1);
    expect_dout(1'b1, d0);
    // Read-side clear zeroes the output but must spare the read strobe
    clr_b_in = 1'b1;
    expect_dout(1'b1, 72'h0);
    clr_b_in = 1'b0;
    ce_b_in = 1'b1;
    // Single-port split: B's RAM sits SP_OFF words above A's
    mode = DPR_MODE_SINGLE;
    sp_split = 1'b1;
    {a_outreg, b_outreg} = 2'b00;
    op(1'b0, 13'h5, d1, 1'b1, 8'hFF, 1'b0);
    op(1'b0, 13'h5, d0, 1'b1, 8'hFE, 1'b0);
    op(1'b1, 13'h5, d0, 1'b1, 8'hFF, 1'b0);
    // A location past the first half is refused
    op(1'b0, SP_OFF + 13'h5, rnd72(), 1'b1, 8'hFF, 1'b0);
    op(1'b0, SP_OFF + 13'h5, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b0, d0);
    op(1'b1, 13'h5, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b1, d0);
    op(1'b0, 13'h5, 72'h0, 1'b0, 8'hFF, 1'b0);
    expect_dout(1'b0, {d0[71:9], d1[8:0]});
    final_report();
  end
endmodule // dpr_ram_tb

`default_nettype wire
